// ==== rtl/boot_sel_pkg.sv ====
// Purpose: Constants shared by the dual image boot selector.
// Assumes: Key words are 32 bits wide; flash reads return one word per request.
// Notes: Byte addresses are those of the unswitched flash map.
package boot_sel_pkg;
   localparam int ADDR_W = 20;
   localparam int KEY_W = 32;
   localparam logic [ADDR_W-1:0] BLK0_BASE = 20'h00000;
   localparam logic [ADDR_W-1:0] BLK1_BASE = 20'h80000;
   localparam logic [ADDR_W-1:0] BLK_LAST = 20'h7FFFF;
   localparam logic [ADDR_W-1:0] KEY1_OFS = 20'h7FFC0;
   localparam logic [ADDR_W-1:0] KEY2_OFS = 20'h7FFC8;
   localparam logic [KEY_W-1:0] KEY_ERASED = 32'hFFFFFFFF;
   localparam logic [KEY_W-1:0] KEY_PROVEN = 32'h00000000;
   localparam logic [KEY_W-1:0] KEY1_FIRST = 32'h00000001;
   localparam logic SWAP_RESET = 1'b0;
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_DEBUG,
      MODE_DOWNLOADER,
      MODE_USER
   } boot_mode_e;
endpackage

// ==== rtl/dual_image_boot_selector.sv ====
// Purpose: Chooses the active flash block and boot mode after every reset.
// Assumes: The flash answers each read with rd_valid a cycle or more later; rd_req is a
//    one-cycle pulse and the next request waits for the answer.
// Notes: Keys are read in the order key1 blk0, key1 blk1, key2 blk0, key2 blk1.
//    Program requests for the downloader keys end in prog_done from the flash side.

// Notes on behaviour
// RULE1 - Strap high: user code, keys ignored; code enters MODE_DEBUG on block zero instead.
// RULE2 - Candidate is image with larger update number.
// RULE3 - Candidate trial marker nonzero: try other image.
// RULE4 - Other marker zero: activate it, enter user.
// RULE5 - Neither marker zero: enter built-in downloader.
// RULE6 - Erased update number compares as minus one.
// RULE7 - User code: smaller active number means trial.
// RULE8 - User code: larger active number means normal.
// RULE9 - Swap bit exchanges blocks at low addresses.
// RULE10 - Swap code sits fixed in first page.
// RULE11 - Software invalidates cache after swap.
// RULE12 - Software zeroes trial marker when image proven.
// RULE13 - Reset after proving boots new image normally.
// RULE14 - Reset during trial restarts old image.
// RULE15 - Download sets new number one above active.
// RULE16 - Download leaves new trial marker erased.
// RULE17 - Reset device after a download.
// RULE18 - Both straps high: serial wire download allowed.
// RULE19 - First download writes number one, marker zero.
// RULE20 - Equal numbers favour the first block.
// RULE21 - Blocks map to low/high halves, swap exchanges.
// RULE22 - Read numbers at key top, markers eight above.
// RULE23 - Modes entered only through selection after reset.
module dual_image_boot_selector (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Straps
   input wire logic download_strap_pin,
   input wire logic serial_wire_strap_pin,
   // Flash key reads
   output logic rd_req,
   output logic [boot_sel_pkg::ADDR_W-1:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [boot_sel_pkg::KEY_W-1:0] rd_data,
   // Downloader key programming
   input wire logic dl_done,
   output logic prog_req,
   output logic [boot_sel_pkg::ADDR_W-1:0] prog_addr,
   output logic [boot_sel_pkg::KEY_W-1:0] prog_data,
   input wire logic prog_done,
   // Swap control from user setup register bit
   input wire logic flash_user_setup_swap,
   // CPU address translation
   input wire logic [boot_sel_pkg::ADDR_W-1:0] cpu_addr,
   output logic [boot_sel_pkg::ADDR_W-1:0] flash_addr,
   // Status
   output logic [1:0] boot_mode,
   output logic active_blk,
   output logic swapped,
   output logic sel_done,
   output logic serial_dl_en
);
   import boot_sel_pkg::*;

   typedef enum logic [3:0] {
      S_STRAP, S_REQ, S_WAIT, S_DECIDE, S_PROG1, S_PROG2, S_WAITPROG, S_DONE
   } state_e;

   state_e state_r;
   logic [1:0] idx_r;
   logic [KEY_W-1:0] k1b0_r, k1b1_r, k2b0_r, k2b1_r;
   logic [1:0] mode_r;
   logic blk_r;
   logic swap_r;
   logic done_r;
   logic sw_en_r;
   logic req_r;
   logic [ADDR_W-1:0] addr_r;
   logic preq_r;
   logic [ADDR_W-1:0] paddr_r;
   logic [KEY_W-1:0] pdata_r;
   logic [ADDR_W-1:0] faddr_r;
   logic prog_step_r;

   // Erased key counts as -1, so compare as signed values. [RULE6]
   logic b1_larger;
   logic cand;
   logic cand_k2_zero, other_k2_zero;
   assign b1_larger = $signed(k1b1_r) > $signed(k1b0_r); // [RULE6] [RULE20]
   assign cand = b1_larger; // [RULE2]
   assign cand_k2_zero = (cand ? k2b1_r : k2b0_r) == KEY_PROVEN;
   assign other_k2_zero = (cand ? k2b0_r : k2b1_r) == KEY_PROVEN;

   function automatic logic [ADDR_W-1:0] key_addr(input logic [1:0] i);
      logic [ADDR_W-1:0] base;
      base = i[0] ? BLK1_BASE : BLK0_BASE;
      key_addr = base + (i[1] ? KEY2_OFS : KEY1_OFS); // [RULE22]
   endfunction

   // Selection runs once per reset; no other path changes the mode. [RULE23]
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= S_STRAP;
         idx_r <= 2'h0;
         mode_r <= MODE_NONE;
         blk_r <= 1'b0;
         done_r <= 1'b0;
         sw_en_r <= 1'b0;
         req_r <= 1'b0;
         addr_r <= BLK0_BASE;
         prog_step_r <= 1'b0;
      end else begin
         req_r <= 1'b0;
         unique case (state_r)
            S_STRAP: begin
               if (download_strap_pin) begin
                  mode_r <= MODE_DEBUG; // [RULE1]
                  blk_r <= 1'b0;
                  sw_en_r <= serial_wire_strap_pin; // [RULE18]
                  done_r <= 1'b1;
                  state_r <= S_DONE;
               end else begin
                  state_r <= S_REQ;
               end
            end
            S_REQ: begin
               req_r <= 1'b1;
               addr_r <= key_addr(idx_r); // [RULE22]
               state_r <= S_WAIT;
            end
            S_WAIT: begin
               if (rd_valid) begin
                  idx_r <= idx_r + 2'h1;
                  state_r <= (idx_r == 2'h3) ? S_DECIDE : S_REQ;
               end
            end
            S_DECIDE: begin
               if (cand_k2_zero) begin
                  mode_r <= MODE_USER; // [RULE2] [RULE13]
                  blk_r <= cand;
                  done_r <= 1'b1;
                  state_r <= S_DONE;
               end else if (other_k2_zero) begin
                  mode_r <= MODE_USER; // [RULE3] [RULE4] [RULE14]
                  blk_r <= ~cand;
                  done_r <= 1'b1;
                  state_r <= S_DONE;
               end else begin
                  mode_r <= MODE_DOWNLOADER; // [RULE5]
                  blk_r <= 1'b0;
                  state_r <= S_PROG1;
               end
            end
            S_PROG1: begin
               if (dl_done) begin
                  prog_step_r <= 1'b0;
                  state_r <= S_PROG2;
               end
            end
            S_PROG2: state_r <= S_WAITPROG;
            S_WAITPROG: begin
               if (prog_done) begin
                  if (prog_step_r) begin
                     done_r <= 1'b1;
                     state_r <= S_DONE;
                  end else begin
                     prog_step_r <= 1'b1;
                     state_r <= S_PROG2;
                  end
               end
            end
            S_DONE: state_r <= S_DONE;
            default: state_r <= S_STRAP;
         endcase
      end
   end

   // Read data capture, indexed by request order.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         k1b0_r <= KEY_ERASED;
         k1b1_r <= KEY_ERASED;
         k2b0_r <= KEY_ERASED;
         k2b1_r <= KEY_ERASED;
      end else if (state_r == S_WAIT && rd_valid) begin
         unique case (idx_r)
            2'h0: k1b0_r <= rd_data;
            2'h1: k1b1_r <= rd_data;
            2'h2: k2b0_r <= rd_data;
            2'h3: k2b1_r <= rd_data;
         endcase
      end
   end

   // Downloader writes number one then marker zero into the first block. [RULE19]
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         preq_r <= 1'b0;
         paddr_r <= BLK0_BASE;
         pdata_r <= KEY_ERASED;
      end else begin
         preq_r <= (state_r == S_PROG2);
         if (state_r == S_PROG2) begin
            paddr_r <= prog_step_r ? BLK0_BASE + KEY2_OFS : BLK0_BASE + KEY1_OFS; // [RULE19]
            pdata_r <= prog_step_r ? KEY_PROVEN : KEY1_FIRST; // [RULE19]
         end
      end
   end

   // Swap bit follows the user setup register once user code runs; reset clears it,
   // so every reset starts from the selected (old) image. [RULE9] [RULE14]
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         swap_r <= SWAP_RESET;
      end else if (mode_r == MODE_USER && done_r) begin
         swap_r <= flash_user_setup_swap; // [RULE9]
      end
   end

   // Low half maps to the active block; the swap bit flips that mapping. [RULE21]
   logic hi_blk;
   assign hi_blk = cpu_addr[ADDR_W-1] ^ blk_r ^ swap_r;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         faddr_r <= BLK0_BASE;
      end else begin
         faddr_r <= {hi_blk, cpu_addr[ADDR_W-2:0]}; // [RULE21] [RULE9]
      end
   end

   assign rd_req = req_r;
   assign rd_addr = addr_r;
   assign prog_req = preq_r;
   assign prog_addr = paddr_r;
   assign prog_data = pdata_r;
   assign flash_addr = faddr_r;
   assign boot_mode = mode_r;
   assign active_blk = blk_r;
   assign swapped = swap_r;
   assign sel_done = done_r;
   assign serial_dl_en = sw_en_r;

   a_strap_debug: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
      (state_r == S_STRAP && download_strap_pin) |=> (mode_r == MODE_DEBUG && done_r))
      else $error("Strap high did not give debug mode.");
   a_cand_pick: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
      (state_r == S_DECIDE && cand_k2_zero) |=> (blk_r == $past(cand) && mode_r == MODE_USER))
      else $error("Proven candidate not chosen.");
   a_other_pick: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE4]
      (state_r == S_DECIDE && !cand_k2_zero && other_k2_zero) |=> (blk_r != $past(cand)))
      else $error("Other proven image not chosen.");
   a_no_valid: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
      (state_r == S_DECIDE && !cand_k2_zero && !other_k2_zero) |=> mode_r == MODE_DOWNLOADER)
      else $error("Downloader not entered.");
   a_erased_low: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE6]
      (k1b1_r == KEY_ERASED && k1b0_r != KEY_ERASED && k1b0_r[KEY_W-1] == 1'b0) |-> !cand)
      else $error("Erased key compared larger.");
   a_equal_blk0: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE20]
      (k1b0_r == k1b1_r) |-> !cand)
      else $error("Equal keys did not favour block zero.");
   a_key_addr: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE22]
      rd_req |-> (rd_addr[6:0] == 7'h40 || rd_addr[6:0] == 7'h48))
      else $error("Key read at wrong offset.");
   a_swap_map: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE21]
      1'b1 |=> flash_addr[ADDR_W-1] == ($past(cpu_addr[ADDR_W-1]) ^ $past(blk_r) ^ $past(swap_r)))
      else $error("Block mapping wrong.");
   a_dl_keys: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE19]
      prog_req |-> (prog_addr == BLK0_BASE + KEY1_OFS && prog_data == KEY1_FIRST) ||
         (prog_addr == BLK0_BASE + KEY2_OFS && prog_data == KEY_PROVEN))
      else $error("Downloader key write wrong.");
   a_mode_hold: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE23]
      done_r |=> (mode_r == $past(mode_r) && blk_r == $past(blk_r)))
      else $error("Mode changed without reset.");

   // Reads go out one at a time; a longer pulse would start a second read
   // before the flash has answered the first.
   a_read_pulse: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE22]
      rd_req |=> !rd_req)
      else $error("Key read request longer than one cycle.");
   a_read_order: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE22]
      rd_req |-> (rd_addr[ADDR_W-1] == idx_r[0] && rd_addr[3] == idx_r[1]))
      else $error("Key read out of order.");

   // Debug mode always runs the first block unswapped, whatever the keys hold.
   a_dbg_block: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
      (mode_r == MODE_DEBUG) |-> (!blk_r && !swap_r && done_r))
      else $error("Debug mode not on block zero.");
   a_serial_dl: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE18]
      sw_en_r |-> (mode_r == MODE_DEBUG))
      else $error("Serial download outside debug mode.");
   a_serial_set: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE18]
      (state_r == S_STRAP && download_strap_pin) |=>
         (sw_en_r == $past(serial_wire_strap_pin)))
      else $error("Serial wire strap not taken.");

   // Both numbers below the sign bit and block one's larger: block one must be the candidate.
   a_larger_cand: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
      (state_r == S_DECIDE && k1b1_r[KEY_W-1] == 1'b0 && k1b0_r[KEY_W-1] == 1'b0 &&
         k1b1_r > k1b0_r) |-> cand)
      else $error("Larger update number not candidate.");
   a_reject_cand: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
      (state_r == S_DECIDE && !cand_k2_zero) |=>
         !(mode_r == MODE_USER && blk_r == $past(cand)))
      else $error("Unproven candidate made active.");
   a_dl_stays: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
      (mode_r == MODE_DOWNLOADER) |=> (mode_r == MODE_DOWNLOADER))
      else $error("Downloader left for user code.");

   // The swap bit only has effect once user code runs, and is gone after a reset.
   a_swap_follow: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE9]
      (mode_r == MODE_USER && done_r) |=> (swapped == $past(flash_user_setup_swap)))
      else $error("Swap bit not followed.");
   a_old_image: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE14]
      (mode_r != MODE_USER) |-> !swap_r)
      else $error("Swap active outside user code.");
endmodule // dual_image_boot_selector

// ==== test/dual_image_boot_selector_tb.sv ====
// Purpose: Self-checking bench for the dual image boot selector.
// Assumes: Key reads are answered by the flash model, promptly or slowly.
// Notes: Every boot goes through a full reset, as the selector only decides there.
module dual_image_boot_selector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import boot_sel_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic strap = 1'b0, sw_strap = 1'b0, dl_done = 1'b0, swap = 1'b0, slow = 1'b0;
   logic rd_req, rd_valid, prog_req, prog_done, addr_err;
   logic [19:0] rd_addr, prog_addr, flash_addr;
   logic [19:0] cpu_addr = 20'h00000;
   logic [31:0] rd_data, prog_data;
   logic [1:0] boot_mode;
   logic active_blk, swapped, sel_done, serial_dl_en;
   int bad_count = 0;
   int num_checks = 0;
   always #20 core_clk = ~core_clk;
   dual_image_boot_selector u_dut (.core_clk(core_clk), .nrst(nrst),
      .download_strap_pin(strap), .serial_wire_strap_pin(sw_strap), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .dl_done(dl_done),
      .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
      .prog_done(prog_done), .flash_user_setup_swap(swap), .cpu_addr(cpu_addr),
      .flash_addr(flash_addr), .boot_mode(boot_mode), .active_blk(active_blk),
      .swapped(swapped), .sel_done(sel_done), .serial_dl_en(serial_dl_en));
   flash_key_model u_flash (.core_clk(core_clk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data), .prog_req(prog_req), .prog_addr(prog_addr),
      .prog_data(prog_data), .prog_done(prog_done), .slow(slow), .addr_err(addr_err));
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // Keys are index 0 k1 blk0, 1 k1 blk1, 2 k2 blk0, 3 k2 blk1.
   task automatic boot(input logic [31:0] k1b0, k2b0, k1b1, k2b1, input logic st, sw);
      int n;
      u_flash.key[0] = k1b0;
      u_flash.key[2] = k2b0;
      u_flash.key[1] = k1b1;
      u_flash.key[3] = k2b1;
      @(posedge core_clk);
      nrst <= 1'b0;
      strap <= st;
      sw_strap <= sw;
      slow <= ~slow;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      n = 0;
      while (sel_done !== 1'b1 && boot_mode !== MODE_DOWNLOADER && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 200) begin
         bad_count++;
         results();
      end
      @(posedge core_clk);
      chk("address", 32'h0, addr_err);
   endtask
   task automatic sel_case(input logic [31:0] k1b0, k2b0, k1b1, k2b1,
                           input logic [1:0] mode, input logic blk);
      boot(k1b0, k2b0, k1b1, k2b1, 1'b0, 1'b0);
      chk("mode", mode, boot_mode);
      if (mode == MODE_USER) chk("block", blk, active_blk);
   endtask
   // User code compares its own update number with the other block's to pick its run.
   task automatic run_kind(input logic exp_trial);
      logic [31:0] own, other;
      own = active_blk ? u_flash.key[1] : u_flash.key[0];
      other = active_blk ? u_flash.key[0] : u_flash.key[1];
      chk("trial run", exp_trial, $signed(own) < $signed(other));
   endtask
   // Trial of a fresh image, then software proves it and resets into it.
   task automatic t_trial();
      sel_case(32'h1, 32'h0, 32'h2, 32'hFFFFFFFF, MODE_USER, 1'b0);
      run_kind(1'b1);
      u_flash.key[3] = KEY_PROVEN;
      sel_case(u_flash.key[0], u_flash.key[2], u_flash.key[1], u_flash.key[3],
               MODE_USER, 1'b1);
      run_kind(1'b0);
   endtask
   task automatic t_debug();
      boot(32'h1, 32'h0, 32'h2, 32'h0, 1'b1, 1'b1);
      chk("debug mode", MODE_DEBUG, boot_mode);
      chk("serial dl", 32'h1, serial_dl_en);
      boot(32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b1, 1'b0);
      chk("debug mode", MODE_DEBUG, boot_mode);
      chk("serial dl", 32'h0, serial_dl_en);
   endtask
   task automatic t_download();
      int n;
      sel_case(32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, MODE_DOWNLOADER, 1'b0);
      dl_done <= 1'b1;
      @(posedge core_clk);
      dl_done <= 1'b0;
      n = 0;
      while (sel_done !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 100) begin
         bad_count++;
         results();
      end
      repeat (2) @(posedge core_clk);
      chk("first number", KEY1_FIRST, u_flash.key[0]);
      chk("first marker", KEY_PROVEN, u_flash.key[2]);
      boot(u_flash.key[0], u_flash.key[2], u_flash.key[1], u_flash.key[3],
           1'b0, 1'b0);
      chk("after download", MODE_USER, boot_mode);
   endtask
   task automatic t_swap();
      sel_case(32'h1, 32'h0, 32'h2, 32'h0, MODE_USER, 1'b1);
      run_kind(1'b0);
      // The swap code fetches from one fixed address in the first page.
      cpu_addr <= 20'h00100;
      repeat (3) @(posedge core_clk);
      chk("unswapped map", 32'h80100, flash_addr);
      swap <= 1'b1;
      // Fetches are judged only after software has flushed its cache.
      repeat (3) @(posedge core_clk);
      chk("swapped map", 32'h00100, flash_addr);
      chk("swap state", 32'h1, swapped);
      swap <= 1'b0;
   endtask
   initial begin
      t_debug();
      sel_case(32'h1, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, MODE_USER, 1'b0);
      run_kind(1'b0);
      // A fresh download carries a number one above and an erased marker.
      sel_case(32'h1, 32'h0, 32'h2, 32'hFFFFFFFF, MODE_USER, 1'b0);
      run_kind(1'b1);
      sel_case(32'h3, 32'hFFFFFFFF, 32'h2, 32'h0, MODE_USER, 1'b1);
      run_kind(1'b1);
      sel_case(32'h3, 32'h0, 32'h3, 32'h0, MODE_USER, 1'b0);
      sel_case(32'h5, 32'hFFFFFFFF, 32'h4, 32'h1, MODE_DOWNLOADER, 1'b0);
      t_download();
      t_trial();
      t_swap();
      results();
   end
endmodule // dual_image_boot_selector_tb

// ==== test/flash_key_model.sv ====
// Purpose: Flash model holding the four image keys and answering key reads and writes.
// Assumes: Keys sit at offsets 0x7FFC0 and 0x7FFC8 of either block.
// Notes: Between answers the read data toggles, so stale data never looks valid.
module flash_key_model (
   // Clock
   input wire logic core_clk,
   // Key reads
   input wire logic rd_req,
   input wire logic [19:0] rd_addr,
   output logic rd_valid,
   output logic [31:0] rd_data,
   // Key programming
   input wire logic prog_req,
   input wire logic [19:0] prog_addr,
   input wire logic [31:0] prog_data,
   output logic prog_done,
   // Control and status
   input wire logic slow,
   output logic addr_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] key [4];
   logic [1:0] idx;
   logic rd_pend = 1'b0;
   logic pr_pend = 1'b0;
   int wait_c;
   initial begin
      rd_valid = 1'b0;
      rd_data = 32'h0;
      prog_done = 1'b0;
      addr_err = 1'b0;
   end
   always @(posedge core_clk) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      pr_pend <= prog_req;
      prog_done <= pr_pend;
      if (prog_req) begin
         key[{prog_addr[3], prog_addr[19]}] <= prog_data;
      end
      if (rd_req) begin
         rd_pend <= 1'b1;
         wait_c <= slow ? 3 : 0;
         idx <= {rd_addr[3], rd_addr[19]};
         if ((rd_addr & 20'h7FFF7) != 20'h7FFC0) addr_err <= 1'b1;
      end else if (rd_pend) begin
         if (wait_c == 0) begin
            rd_valid <= 1'b1;
            rd_data <= key[idx];
            rd_pend <= 1'b0;
         end else begin
            wait_c <= wait_c - 1;
         end
      end
   end
endmodule // flash_key_model
